// file: hdl/sci_core.v
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`include "sci_core_defs.vh"
module sci_core #(
	parameter BAUD_W = 8
) (
	// Clock and reset.
	input  wire       i_clock,
	input  wire       i_rst,
	// Register port.
	input  wire [2:0] i_addr,
	input  wire [7:0] i_wdata,
	input  wire       i_wr,
	input  wire       i_rd,
	output reg  [7:0] o_rdata,
	// Processor interrupt mask.
	input  wire       i_cpu_mask_flag,
	output wire       o_irq,
	// Serial pins.
	input  wire       i_serial_rx_pin,
	output reg        o_serial_tx_pin,
	output wire       o_tx_pin_owned
);

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
reg  [7:0] ctrl_one_q;
reg  [7:0] ctrl_two_q;
reg  [7:0] baud_q;
reg  [7:0] tx_hold_q;
reg        tx_hold_full_q;
reg  [7:0] rx_hold_q;
reg        tx_empty_q, tx_done_q, rx_full_q, idle_q, overrun_q, noise_q, framing_q;
reg        status_seen_q;
reg        noise_latent_q;

wire       word9     = ctrl_one_q[`CR1_WORD_LEN];
wire       tx_en     = ctrl_two_q[`CR2_TX_EN];
wire       rx_en     = ctrl_two_q[`CR2_RX_EN];
wire       brk       = ctrl_two_q[`CR2_BREAK];
wire       wr_data   = i_wr && (i_addr == `REG_DATA);
wire       rd_data   = i_rd && (i_addr == `REG_DATA);
wire       rd_stat   = i_rd && (i_addr == `REG_STATUS);
wire       tx_clear  = wr_data && status_seen_q;
wire       rx_clear  = rd_data && status_seen_q;

// Pin ownership: enabled means serial function, else general I/O.
assign o_tx_pin_owned = tx_en | rx_en;

// ----------------------------------------------------------------
// Baud generators
// ----------------------------------------------------------------
// Each generator counts CPU cycles to a 16x oversample tick.
// Separate counters allow different transmit and receive rates.
reg  [BAUD_W-1:0] tx_div_q, rx_div_q;
wire tx_tick = (tx_div_q == {BAUD_W{1'b0}});
wire rx_tick = (rx_div_q == {BAUD_W{1'b0}});

always @(posedge i_clock or posedge i_rst) begin
	if (i_rst) begin
		tx_div_q <= {BAUD_W{1'b0}};
		rx_div_q <= {BAUD_W{1'b0}};
	end else begin
		tx_div_q <= tx_tick ? {4'h0, baud_q[3:0]} : tx_div_q - 1'b1;
		rx_div_q <= rx_tick ? {4'h0, baud_q[7:4]} : rx_div_q - 1'b1;
	end
end

// ----------------------------------------------------------------
// Input synchroniser
// ----------------------------------------------------------------
reg rx_meta_q, rx_sync_q;
always @(posedge i_clock or posedge i_rst) begin
	if (i_rst) begin
		rx_meta_q <= 1'b1;
		rx_sync_q <= 1'b1;
	end else begin
		rx_meta_q <= i_serial_rx_pin;
		rx_sync_q <= rx_meta_q;
	end
end

// ----------------------------------------------------------------
// Transmitter
// ----------------------------------------------------------------
localparam TX_IDLE = 4'b0001;
localparam TX_SEND = 4'b0010;
localparam TX_MARK = 4'b0100;
localparam TX_OFF  = 4'b1000;

reg [3:0] tx_state_q;
reg [10:0] tx_shift_q;
reg [3:0]  tx_bit_q;
reg [3:0]  tx_sub_q;
reg        tx_en_q;
reg        idle_pend_q;
reg        brk_last_q;
wire [3:0] frame_bits = word9 ? 4'd11 : 4'd10;
wire       tx_bit_end = tx_tick && (tx_sub_q == 4'hF);
wire       tx_frame_end = tx_bit_end && (tx_bit_q == frame_bits - 4'd1);

// Frame builder: stop, data LSB first, start (bit 0 goes first).
function [10:0] build_frame;
	input [7:0] data;
	input       ninth;
	input       nine;
	begin
		build_frame = nine ? {1'b1, ninth, data, 1'b0} : {2'b11, data, 1'b0};
	end
endfunction

always @(posedge i_clock or posedge i_rst) begin
	if (i_rst) begin
		tx_state_q      <= TX_OFF;
		tx_shift_q      <= 11'h7FF;
		tx_bit_q        <= 4'h0;
		tx_sub_q        <= 4'h0;
		tx_en_q         <= 1'b0;
		idle_pend_q     <= 1'b0;
		brk_last_q      <= 1'b0;
		o_serial_tx_pin <= 1'b1;
		tx_hold_full_q  <= 1'b0;
		tx_hold_q       <= 8'h00;
	end else begin
		tx_en_q <= tx_en;
		// A rising tx_enable queues an idle frame and drops queued data.
		if (tx_en && !tx_en_q) begin
			idle_pend_q    <= 1'b1;
			tx_hold_full_q <= 1'b0;
		end else if (wr_data && tx_state_q != TX_IDLE) begin
			tx_hold_q      <= i_wdata;
			tx_hold_full_q <= 1'b1;
		end
		if (tx_tick)
			tx_sub_q <= tx_sub_q + 4'h1;
		case (tx_state_q)
			TX_OFF: begin
				o_serial_tx_pin <= 1'b1;
				if (tx_en)
					tx_state_q <= TX_IDLE;
			end
			TX_IDLE: begin
				o_serial_tx_pin <= 1'b1;
				tx_bit_q <= 4'h0;
				tx_sub_q <= 4'h0;
				if (!tx_en) begin
					tx_state_q <= TX_OFF;
				end else if (idle_pend_q) begin
					idle_pend_q <= 1'b0;
					tx_shift_q  <= 11'h7FF;
					tx_state_q  <= TX_SEND;
				end else if (brk) begin
					tx_shift_q <= 11'h000;
					brk_last_q <= 1'b1;
					tx_state_q <= TX_SEND;
				end else if (brk_last_q) begin
					brk_last_q <= 1'b0;
					tx_state_q <= TX_MARK;
				end else if (wr_data) begin
					tx_shift_q <= build_frame(i_wdata, ctrl_one_q[`CR1_TX_NINTH], word9);
					tx_state_q <= TX_SEND;
				end else if (tx_hold_full_q) begin
					tx_shift_q     <= build_frame(tx_hold_q, ctrl_one_q[`CR1_TX_NINTH], word9);
					tx_hold_full_q <= 1'b0;
					tx_state_q     <= TX_SEND;
				end
			end
			TX_SEND: begin
				o_serial_tx_pin <= tx_shift_q[0];
				if (tx_bit_end) begin
					tx_shift_q <= {1'b1, tx_shift_q[10:1]};
					tx_bit_q   <= tx_bit_q + 4'h1;
				end
				if (tx_frame_end)
					tx_state_q <= TX_IDLE;
			end
			TX_MARK: begin
				o_serial_tx_pin <= 1'b1;
				if (tx_bit_end)
					tx_state_q <= TX_IDLE;
			end
			default: tx_state_q <= TX_OFF;
		endcase
	end
end

wire tx_load = (tx_state_q == TX_IDLE) && tx_en && !idle_pend_q && !brk && !brk_last_q
	&& (wr_data || tx_hold_full_q);
wire tx_done_evt = (tx_state_q == TX_SEND) && tx_frame_end;

// ----------------------------------------------------------------
// Receiver
// ----------------------------------------------------------------
localparam RX_HUNT  = 3'b001;
localparam RX_START = 3'b010;
localparam RX_DATA  = 3'b100;

reg [2:0] rx_state_q;
reg [3:0] rx_sub_q;
reg [3:0] rx_bit_q;
reg [9:0] rx_shift_q;
reg [2:0] rx_samp_q;
reg       rx_noise_q;
reg       rx_prev_q;
wire      rx_vote = (rx_samp_q[0] & rx_samp_q[1]) | (rx_samp_q[0] & rx_samp_q[2]) | (rx_samp_q[1] & rx_samp_q[2]);
wire      rx_split = (rx_samp_q != 3'b000) && (rx_samp_q != 3'b111);
wire      rx_decide = rx_tick && (rx_sub_q == 4'hA);
wire      rx_bit_last = (rx_bit_q == (word9 ? 4'd10 : 4'd9));
wire      rx_done = (rx_state_q == RX_DATA) && rx_decide && rx_bit_last;
wire [9:0] rx_frame = {rx_vote, rx_shift_q[9:1]};
wire      rx_stop_bad = !rx_vote;
// In 8-bit mode the word sits one place higher, because one bit fewer was shifted in.
wire [8:0] rx_data9 = word9 ? rx_frame[8:0] : {1'b0, rx_frame[8:1]};
wire      rx_is_break = (rx_data9 == 9'h000) && rx_stop_bad;
reg [7:0] rx_quiet_q;
reg       rx_arm_q;
wire      rx_idle_evt = (rx_state_q == RX_HUNT) && rx_en && rx_arm_q && rx_tick
	&& (rx_quiet_q == (word9 ? 8'hAF : 8'h9F));

// Quiet-line timer; only one idle report per stretch of silence after a received frame, reset or receiver enable.
always @(posedge i_clock or posedge i_rst) begin
	if (i_rst) begin
		rx_quiet_q <= 8'h00;
		rx_arm_q   <= 1'b1;
	end else begin
		if (rx_state_q != RX_HUNT || !rx_sync_q || !rx_en)
			rx_quiet_q <= 8'h00;
		else if (rx_tick)
			rx_quiet_q <= rx_quiet_q + 8'h01;
		if (!rx_en || rx_done)
			rx_arm_q <= 1'b1;
		else if (rx_idle_evt)
			rx_arm_q <= 1'b0;
	end
end

always @(posedge i_clock or posedge i_rst) begin
	if (i_rst) begin
		rx_state_q <= RX_HUNT;
		rx_sub_q   <= 4'h0;
		rx_bit_q   <= 4'h0;
		rx_shift_q <= 10'h000;
		rx_samp_q  <= 3'h7;
		rx_noise_q <= 1'b0;
		rx_prev_q  <= 1'b1;
	end else begin
		rx_prev_q <= rx_sync_q;
		if (rx_tick) begin
			rx_sub_q <= rx_sub_q + 4'h1;
			// Samples 8, 9, 10 of each bit feed the vote.
			if (rx_sub_q >= 4'h7 && rx_sub_q <= 4'h9)
				rx_samp_q <= {rx_samp_q[1:0], rx_sync_q};
		end
		case (rx_state_q)
			RX_HUNT: begin
				rx_bit_q <= 4'h0;
				// A falling edge restarts the sample phase.
				if (rx_en && rx_prev_q && !rx_sync_q) begin
					rx_sub_q   <= 4'h0;
					rx_state_q <= RX_START;
				end
			end
			RX_START: begin
				if (rx_decide) begin
					if (rx_samp_q == 3'b000) begin
						rx_state_q <= RX_DATA;
						rx_bit_q   <= 4'h1;
					end else begin
						rx_noise_q <= rx_noise_q | rx_split;
						rx_state_q <= RX_HUNT;
					end
				end
			end
			RX_DATA: begin
				if (rx_decide) begin
					rx_shift_q <= rx_frame;
					rx_bit_q   <= rx_bit_q + 4'h1;
					if (rx_split)
						rx_noise_q <= 1'b1;
					if (rx_bit_last)
						rx_state_q <= RX_HUNT;
				end
				if (rx_tick && rx_sub_q == 4'hF)
					rx_sub_q <= 4'h0;
			end
			default: rx_state_q <= RX_HUNT;
		endcase
		if (rx_done)
			rx_noise_q <= 1'b0;
		if (!rx_en)
			rx_state_q <= RX_HUNT;
	end
end

// ----------------------------------------------------------------
// Flags, buffers and register writes
// ----------------------------------------------------------------
// Hardware sets win over the software clearing sequence.
always @(posedge i_clock or posedge i_rst) begin
	if (i_rst) begin
		ctrl_one_q    <= 8'h00;
		ctrl_two_q    <= 8'h00;
		baud_q        <= `BAUD_RESET;
		rx_hold_q     <= 8'h00;
		tx_empty_q    <= 1'b1;
		tx_done_q     <= 1'b1;
		rx_full_q     <= 1'b0;
		idle_q        <= 1'b0;
		overrun_q     <= 1'b0;
		noise_q       <= 1'b0;
		framing_q     <= 1'b0;
		status_seen_q <= 1'b0;
	end else begin
		if (rd_stat)
			status_seen_q <= 1'b1;
		else if (rd_data || wr_data)
			status_seen_q <= 1'b0;
		if (i_wr && i_addr == `REG_CTRL_ONE)
			ctrl_one_q <= {ctrl_one_q[7], i_wdata[6:0]};
		if (i_wr && i_addr == `REG_CTRL_TWO)
			ctrl_two_q <= i_wdata;
		if (i_wr && i_addr == `REG_BAUD)
			baud_q <= i_wdata;
		if (tx_clear) begin
			tx_empty_q <= 1'b0;
			tx_done_q  <= 1'b0;
		end
		if (tx_load)
			tx_empty_q <= 1'b1;
		if (tx_done_evt)
			tx_done_q <= 1'b1;
		if (rx_clear) begin
			rx_full_q <= 1'b0;
			idle_q    <= 1'b0;
			overrun_q <= 1'b0;
			noise_q   <= 1'b0;
			framing_q <= 1'b0;
		end
		if (rx_done || rx_idle_evt) begin
			if (rx_full_q && !rx_clear) begin
				overrun_q <= 1'b1;
			end else begin
				rx_full_q  <= 1'b1;
				rx_hold_q  <= rx_idle_evt ? 8'hFF : rx_data9[7:0];
				ctrl_one_q[`CR1_RX_NINTH] <= rx_data9[8] && !rx_idle_evt;
				noise_q    <= rx_noise_q || (rx_done && rx_split);
				framing_q  <= rx_done && (rx_stop_bad || rx_is_break);
				idle_q     <= rx_idle_evt;
			end
		end
	end
end

// Interrupt gathering, masked by the processor flag.
assign o_irq = !i_cpu_mask_flag && (
	(tx_empty_q && ctrl_two_q[`CR2_TX_EMPTY_IE]) ||
	(tx_done_q  && ctrl_two_q[`CR2_TX_DONE_IE])  ||
	((rx_full_q || overrun_q) && ctrl_two_q[`CR2_RX_IE]) ||
	(idle_q && ctrl_two_q[`CR2_IDLE_IE]));

// Read data appear one cycle after the read strobe.
always @(posedge i_clock or posedge i_rst) begin
	if (i_rst) begin
		o_rdata <= 8'h00;
	end else if (i_rd) begin
		case (i_addr)
			`REG_STATUS:   o_rdata <= {tx_empty_q, tx_done_q, rx_full_q, idle_q, overrun_q, noise_q, framing_q, 1'b0};
			`REG_DATA:     o_rdata <= rx_hold_q;
			`REG_BAUD:     o_rdata <= baud_q;
			`REG_CTRL_ONE: o_rdata <= ctrl_one_q;
			`REG_CTRL_TWO: o_rdata <= ctrl_two_q;
			default:       o_rdata <= 8'h00;
		endcase
	end else begin
		o_rdata <= 8'h00;
	end
end

endmodule // sci_core

// file: inc/sci_core_defs.vh
`ifndef SCI_CORE_DEFS_VH
`define SCI_CORE_DEFS_VH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define REG_STATUS      3'h0
`define REG_DATA        3'h1
`define REG_BAUD        3'h2
`define REG_CTRL_ONE    3'h3
`define REG_CTRL_TWO    3'h4
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CR1_RX_NINTH    7
`define CR1_TX_NINTH    6
`define CR1_WORD_LEN    4
`define CR2_TX_EMPTY_IE 7
`define CR2_TX_DONE_IE  6
`define CR2_RX_IE       5
`define CR2_IDLE_IE     4
`define CR2_TX_EN       3
`define CR2_RX_EN       2
`define CR2_BREAK       0
`define SR_TX_EMPTY     7
`define SR_TX_DONE      6
`define SR_RX_FULL      5
`define SR_IDLE         4
`define SR_OVERRUN      3
`define SR_NOISE        2
`define SR_FRAMING      1
// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define BAUD_RESET      8'h00
`define OVERSAMPLE      16
`endif

// file: sim/far_end_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Far-end serial device
// ----------------------------------------
module far_end_model (
	// Timing clock.
	input  wire i_clock,
	// Lines from and to the core.
	input  wire i_line,
	output reg  o_line
);
	initial o_line = 1'b1;

	// Send one frame; a glitch bit is flipped for one sample slot just past mid-bit.
	task send(input logic [8:0] d, input int nb, input int bp, input logic [8:0] gl, input logic stp);
		logic [10:0] f;
		logic [10:0] g;
		f = {1'b1, d, 1'b0};
		g = {1'b0, gl, 1'b0};
		f[nb + 1] = stp;
		for (int i = 0; i < nb + 2; i++) begin
			for (int c = 0; c < bp; c++) begin
				@(posedge i_clock);
				o_line <= f[i] ^ (g[i] && c >= bp / 2 + 2 && c < bp / 2 + 2 + bp / 16);
			end
		end
		@(posedge i_clock);
		o_line <= 1'b1;
	endtask

	// Take one frame at mid-bit; sampling on the falling edge avoids racing the core's updates.
	task recv(input int nb, input int bp, output logic [8:0] d, output logic stp, output int idle);
		d = 9'h000;
		idle = 0;
		while (!i_line && idle < 4000) begin
			@(negedge i_clock);
			idle++;
		end
		while (i_line && idle < 4000) begin
			@(negedge i_clock);
			idle++;
		end
		repeat (bp / 2) @(negedge i_clock);
		for (int i = 0; i <= nb; i++) begin
			repeat (bp) @(negedge i_clock);
			if (i < nb) d[i] = i_line;
			else stp = i_line;
		end
	endtask
endmodule // far_end_model

// file: sim/sci_core_sva.sv
`timescale 1ns/100ps
`include "sci_core_defs.vh"
// ----------------------------------------
// Port checker
// ----------------------------------------
module sci_core_sva #(
	parameter BAUD_W = 8
) (
	// Clock, reset and register port.
	input wire       i_clock,
	input wire       i_rst,
	input wire [2:0] i_addr,
	input wire [7:0] i_wdata,
	input wire       i_wr,
	input wire       i_rd,
	input wire [7:0] o_rdata,
	// Interrupt and serial pins.
	input wire       i_cpu_mask_flag,
	input wire       o_irq,
	input wire       i_serial_rx_pin,
	input wire       o_serial_tx_pin,
	input wire       o_tx_pin_owned
);
	reg  [7:0]  baud_q;
	reg  [7:0]  ctl_q;
	reg         prev_q;
	reg  [15:0] run_q;
	wire [15:0] bitp = {7'h00, baud_q[3:0] + 5'h01, 4'h0};

	// Shadow setup writes and time each level run; baud is only changed while disabled.
	always @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			baud_q <= `BAUD_RESET;
			ctl_q  <= 8'h00;
			prev_q <= 1'b1;
			run_q  <= 16'h0000;
		end else begin
			if (i_wr && i_addr == `REG_BAUD) baud_q <= i_wdata;
			if (i_wr && i_addr == `REG_CTRL_TWO) ctl_q <= i_wdata;
			prev_q <= o_serial_tx_pin;
			run_q  <= (o_serial_tx_pin != prev_q) ? 16'h0001 : run_q + 16'h0001;
		end
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	sequence s_bad_rd;
		i_rd && i_addr > `REG_CTRL_TWO;
	endsequence
	sequence s_rise;
		o_serial_tx_pin && !prev_q;
	endsequence
	sequence s_fall;
		!o_serial_tx_pin && prev_q && o_tx_pin_owned;
	endsequence

	// Port relations.
	a_reset_line_idle: assert property ($past(i_rst) |-> o_serial_tx_pin && !o_tx_pin_owned && o_rdata == 8'h00)
		else $error("line not idle after reset");
	a_read_gap_zero: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside its cycle");
	a_unmapped_zero: assert property (s_bad_rd |=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_irq_masked: assert property (i_cpu_mask_flag |-> !o_irq)
		else $error("interrupt while masked");
	a_irq_needs_en: assert property (ctl_q[7:4] == 4'h0 |-> !o_irq)
		else $error("interrupt without enable");
	a_pin_owned: assert property (o_tx_pin_owned == (ctl_q[3] | ctl_q[2]))
		else $error("pin ownership wrong");
	a_low_whole_bits: assert property (s_rise |-> run_q % bitp == 16'h0000)
		else $error("low run not whole bits");
	a_stop_bit_high: assert property (s_fall |-> run_q >= bitp)
		else $error("high run before start too short");
endmodule // sci_core_sva

bind sci_core sci_core_sva #(.BAUD_W(BAUD_W)) chk (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cpu_mask_flag(i_cpu_mask_flag),
	.o_irq(o_irq), .i_serial_rx_pin(i_serial_rx_pin), .o_serial_tx_pin(o_serial_tx_pin),
	.o_tx_pin_owned(o_tx_pin_owned));

// file: sim/testbench.sv
`timescale 1ns/100ps
`include "sci_core_defs.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; $display("mismatch at %0t: %h %h", $time, a, e); end end
module testbench;
	reg         i_clock;
	reg         i_rst;
	reg  [2:0]  i_addr;
	reg  [7:0]  i_wdata;
	reg         i_wr;
	reg         i_rd;
	reg         i_cpu_mask_flag;
	wire [7:0]  o_rdata;
	wire        o_irq;
	wire        o_serial_tx_pin;
	wire        o_tx_pin_owned;
	wire        rx_line;
	int         fails = 0;
	int         checks = 0;
	int         idle;
	logic [7:0] s;
	logic [8:0] d;
	logic       stp;
	// Rows: nine-bit mode flag over the nine-bit word.
	logic [9:0] rows [0:3] = '{10'h0A5, 10'h180, 10'h35A, 10'h2FF};

	sci_core #(.BAUD_W(8)) uut (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cpu_mask_flag(i_cpu_mask_flag), .o_irq(o_irq),
		.i_serial_rx_pin(rx_line), .o_serial_tx_pin(o_serial_tx_pin), .o_tx_pin_owned(o_tx_pin_owned));
	far_end_model partner (.i_clock(i_clock), .i_line(o_serial_tx_pin), .o_line(rx_line));

	// ----------------------------------------
	// Bus and link tasks
	// ----------------------------------------
	task wr(input [2:0] a, input [7:0] v);
		@(posedge i_clock);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask
	task rd(input [2:0] a);
		@(posedge i_clock);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_rd <= 1'b0;
		@(negedge i_clock);
		s = o_rdata;
	endtask
	// Transmit side runs at 16 cycles a bit; a silent line ends the run.
	task tx_get(input int nb);
		partner.recv(nb, 16, d, stp, idle);
		if (idle >= 4000) begin
			fails++;
			final_report;
		end
	endtask
	task final_report;
		if (fails == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Clock and overall watchdog.
	initial begin
		i_clock = 1'b0;
		forever #50 i_clock = ~i_clock;
	end
	initial begin
		repeat (100000) @(posedge i_clock);
		fails++;
		final_report;
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		i_rst = 1'b1;
		i_addr = 3'h0;
		i_wdata = 8'h00;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_cpu_mask_flag = 1'b0;
		repeat (5) @(posedge i_clock);
		i_rst <= 1'b0;
		rd(`REG_STATUS);
		`CHK(s, 8'hC0)
		rd(`REG_CTRL_TWO);
		`CHK(s, 8'h00)
		wr(3'h7, 8'hFF);
		rd(3'h7);
		`CHK(s, 8'h00)
		// Receive bits take 64 cycles, transmit bits 16, so the two generators must differ.
		wr(`REG_BAUD, 8'h30);
		wr(`REG_CTRL_TWO, 8'h08);
		rd(`REG_STATUS);
		wr(`REG_DATA, 8'hA5);
		rd(`REG_STATUS);
		`CHK(s[7], 1'b0)
		tx_get(8);
		`CHK(idle >= 150, 1'b1)
		`CHK({stp, d}, 10'h2A5)
		rd(`REG_STATUS);
		wr(`REG_DATA, 8'h3C);
		rd(`REG_STATUS);
		`CHK(s[7:6], 2'b00)
		tx_get(8);
		`CHK({stp, d}, 10'h23C)
		rd(`REG_STATUS);
		`CHK(s[7], 1'b1)
		repeat (16) @(posedge i_clock);
		rd(`REG_STATUS);
		`CHK(s[7:6], 2'b11)
		rd(`REG_STATUS);
		wr(`REG_DATA, 8'h96);
		rd(`REG_STATUS);
		`CHK(s[7], 1'b1)
		wr(`REG_CTRL_TWO, 8'h0C);
		repeat (800) @(posedge i_clock);
		rd(`REG_STATUS);
		`CHK(s[5:4], 2'b11)
		rd(`REG_DATA);
		rd(`REG_STATUS);
		`CHK(s[5], 1'b0)
		foreach (rows[i]) begin
			wr(`REG_CTRL_ONE, {1'b0, rows[i][8], 1'b0, rows[i][9], 4'h0});
			rd(`REG_STATUS);
			wr(`REG_DATA, rows[i][7:0]);
			fork
				tx_get(8 + rows[i][9]);
				partner.send(rows[i][8:0], 8 + rows[i][9], 64, 9'h000, 1'b1);
			join
			`CHK(d, rows[i][9] ? rows[i][8:0] : {1'b0, rows[i][7:0]})
			rd(`REG_STATUS);
			`CHK(s & 8'h2E, 8'h20)
			rd(`REG_DATA);
			`CHK(s, rows[i][7:0])
			rd(`REG_CTRL_ONE);
			`CHK(s[7] & rows[i][9], rows[i][8] & rows[i][9])
		end
		// Noise, overrun and a received break, back to back.
		wr(`REG_CTRL_ONE, 8'h00);
		partner.send(9'h00F, 8, 64, 9'h004, 1'b1);
		rd(`REG_STATUS);
		`CHK(s & 8'h2E, 8'h24)
		rd(`REG_DATA);
		`CHK(s, 8'h0F)
		partner.send(9'h011, 8, 64, 9'h000, 1'b1);
		partner.send(9'h022, 8, 64, 9'h000, 1'b1);
		rd(`REG_STATUS);
		`CHK(s & 8'h2E, 8'h28)
		rd(`REG_DATA);
		`CHK(s, 8'h11)
		rd(`REG_STATUS);
		`CHK(s & 8'h28, 8'h00)
		partner.send(9'h000, 8, 64, 9'h000, 1'b0);
		rd(`REG_STATUS);
		`CHK(s & 8'h22, 8'h22)
		rd(`REG_DATA);
		`CHK(s, 8'h00)
		// Transmit break, then data behind it.
		wr(`REG_CTRL_TWO, 8'h0D);
		tx_get(8);
		`CHK({stp, d}, 10'h000)
		wr(`REG_CTRL_TWO, 8'h0C);
		rd(`REG_STATUS);
		wr(`REG_DATA, 8'h55);
		tx_get(8);
		`CHK({stp, d}, 10'h255)
		// Interrupt enables and mask.
		rd(`REG_STATUS);
		rd(`REG_DATA);
		wr(`REG_CTRL_TWO, 8'h8C);
		@(negedge i_clock);
		`CHK(o_irq, 1'b1)
		@(posedge i_clock);
		i_cpu_mask_flag <= 1'b1;
		@(negedge i_clock);
		`CHK(o_irq, 1'b0)
		@(posedge i_clock);
		i_cpu_mask_flag <= 1'b0;
		repeat (16) @(posedge i_clock);
		wr(`REG_CTRL_TWO, 8'h4C);
		@(negedge i_clock);
		`CHK(o_irq, 1'b1)
		wr(`REG_CTRL_TWO, 8'h2C);
		@(negedge i_clock);
		`CHK(o_irq, 1'b0)
		partner.send(9'h05A, 8, 64, 9'h000, 1'b1);
		@(negedge i_clock);
		`CHK(o_irq, 1'b1)
		final_report;
	end
endmodule // testbench
